// [rsc_pkg.sv]
package rsc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_LOOP = 6'h13;
  localparam logic [5:0] IDX_PRIO = 6'h14;
  localparam logic [5:0] IDX_MODE = 6'h15;
  localparam logic [5:0] IDX_HOLD = 6'h16;
  localparam logic [5:0] IDX_CDIV = 6'h17;
  localparam logic [5:0] IDX_STAT = 6'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SEL_LSB      = 0;
  localparam int MODE_LSB     = 2;
  localparam int REVERTIVE_SWITCH_EN_BIT     = 4;
  localparam int PRESCALE_BIT = 5;
  localparam int OFS_LSB      = 0;
  localparam int OFSEN_BIT    = 5;
  localparam int PUMP_LSB     = 8;
  localparam int AMP_LSB      = 16;
  localparam int FMT_BIT      = 18;
  localparam int STAT_LOS_LSB = 4;

  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0]  PRIO_RST  = 8'he0;
  localparam logic [7:0]  MODE_RST  = 8'h00;
  localparam logic [7:0]  HOLD_RST  = 8'h80;
  localparam logic [7:0]  CDIV_RST  = 8'h80;
  localparam logic [31:0] LOOP_RST  = 32'h0000_1800;
  localparam logic [7:0]  MODE_MASK = 8'h7f;
  localparam logic [7:0]  CDIV_MASK = 8'hcf;
  localparam logic [31:0] LOOP_MASK = 32'h0007_1f3f;

  // ----------------------------------------------------------------
  // loop setting scales and response codes
  // ----------------------------------------------------------------
  localparam logic [3:0]  OFS_STEP_TENTHS = 4'h9;
  localparam logic [7:0]  PUMP_STEP_UA    = 8'hc8;
  localparam logic [9:0]  AMP_LOW_MV      = 10'h0fa;
  localparam logic [9:0]  AMP_MID_MV      = 10'h1f4;
  localparam logic [9:0]  AMP_HIGH_MV     = 10'h2ee;
  localparam logic [2:0]  DIV_FAST        = 3'h1;
  localparam logic [2:0]  DIV_SLOW        = 3'h4;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {
    SEL_MANUAL = 2'b00,
    SEL_RESEL  = 2'b01,
    SEL_TRACK  = 2'b11
  } rsc_sel_e;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } rsc_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rsc_axi_rsp_s;

  typedef struct packed {
    logic [4:0]  phase_offset_code;
    logic [8:0]  phase_offset_tenths;
    logic [4:0]  synth_pump_current_code;
    logic [12:0] pump_current_ua;
    logic [1:0]  aux_osc_amplitude_code;
    logic [9:0]  aux_osc_amplitude_mv;
    logic        output_format_sel;
    logic        activity_prescale_sel;
    logic [2:0]  activity_div_ratio;
    logic [1:0]  activity_counter_cfg;
  } rsc_loop_cfg_s;

endpackage

// [rsc_ref_select.sv]
// Contract
// [R01] two-bit rank code 00 lowest, 11 highest
// [R02] equal rank: lower input index wins
// [R03] revertive off: revalidation keeps current reference
// [R04] revertive on: reselect, switch only if outranks
// [R05] revertive bit ignored in manual modes
// [R06] prescale bit divides monitor by 1 or 4
// [R07] offset enable gates static phase offset
// [R08] phase offset is code times 0.9 degrees
// [R09] pump current 200uA times code plus one
// [R10] amplitude 00 250, 01/10 500, 11 750mV
// [R11] auto modes: selector picks; manual: field decides
// [R12] mode code low bit set means automatic
// [R13] manual field 00 input0, 01 input1
// [R14] pick highest rank among inputs without loss
// [R15] selection changes on a clean clock edge
module rsc_ref_select (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic [3:0]             ref_los,
  input  wire rsc_pkg::rsc_axi_req_s  axi_req,
  output      rsc_pkg::rsc_axi_rsp_s  axi_rsp,
  output      logic [1:0]             ref_sel,
  output      logic                   auto_active,
  output      rsc_pkg::rsc_loop_cfg_s loop_cfg
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]            prio;
    logic [7:0]            mode;
    logic [7:0]            hold;
    logic [7:0]            cdiv;
    logic [31:0]           loop;
    logic [3:0]            los_m;
    logic [3:0]            los_s;
    logic [3:0]            los_p;
    logic [1:0]            sel;
    rsc_pkg::rsc_sel_e     st;
    logic                  aw_got;
    logic [7:0]            awaddr;
    logic                  w_got;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    rsc_pkg::rsc_axi_rsp_s rsp;
    rsc_pkg::rsc_loop_cfg_s cfg;
  } rsc_state_s;

  rsc_state_s q;
  rsc_state_s n;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] rank_key(input logic [7:0] pr,
                                          input logic [1:0] i);
    logic [7:0] sh;
    sh = pr >> (3'd6 - {i, 1'b0});
    return {sh[1:0], ~i}; // R01 R02
  endfunction

  function automatic logic [2:0] best_pick(input logic [7:0] pr,
                                           input logic [3:0] los);
    logic [2:0] b;
    logic [3:0] k;
    logic [3:0] bk;
    b  = 3'h0;
    bk = 4'h0;
    for (int i = 0; i < 4; i++) begin
      k = rank_key(pr, 2'(i));
      if (!los[i] && (!b[2] || k > bk)) begin // R14
        b  = {1'b1, 2'(i)};
        bk = k;
      end
    end
    return b;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [5:0] idx);
    return idx >= rsc_pkg::IDX_LOOP && idx <= rsc_pkg::IDX_STAT;
  endfunction

  function automatic logic [9:0] amp_mv(input logic [1:0] c);
    unique case (c)
      2'b00:   return rsc_pkg::AMP_LOW_MV; // R10
      2'b11:   return rsc_pkg::AMP_HIGH_MV;
      default: return rsc_pkg::AMP_MID_MV;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // selection terms
  // ----------------------------------------------------------------
  logic       is_auto;
  logic       revertive_switch_en_on;
  logic       cur_lost;
  logic [3:0] reval;
  logic [2:0] best;
  logic       outranks;

  // only the low mode bit tells manual from automatic
  assign is_auto  = q.mode[rsc_pkg::MODE_LSB]; // R11 R12
  assign revertive_switch_en_on  = q.mode[rsc_pkg::REVERTIVE_SWITCH_EN_BIT] & is_auto; // R05
  assign cur_lost = q.los_s[q.sel];
  assign reval    = q.los_p & ~q.los_s & ~(4'h1 << q.sel);
  assign best     = best_pick(q.prio, q.los_s);
  assign outranks = rank_key(q.prio, best[1:0]) > rank_key(q.prio, q.sel);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [5:0]  widx;
    logic [5:0]  ridx;
    logic [31:0] wm;
    logic [31:0] rd;
    widx = q.awaddr[7:2];
    ridx = axi_req.araddr[7:2];
    wm   = merge(32'h0, q.wdata, q.wstrb);
    rd   = 32'h0;
    n    = q;

    // los arrives from the pin side; the first stage feeds only the second
    n.los_m = ref_los;
    n.los_s = q.los_m;
    n.los_p = q.los_s;

    unique case (q.st)
      rsc_pkg::SEL_MANUAL: begin
        n.sel = q.mode[rsc_pkg::SEL_LSB +: 2]; // R13
        if (is_auto) begin
          n.st = rsc_pkg::SEL_RESEL;
        end
      end
      rsc_pkg::SEL_TRACK: begin
        if (!is_auto) begin
          n.st = rsc_pkg::SEL_MANUAL;
        end else if (cur_lost || (revertive_switch_en_on && |reval)) begin // R03 R04
          n.st = rsc_pkg::SEL_RESEL;
        end
      end
      rsc_pkg::SEL_RESEL: begin
        if (!is_auto) begin
          n.st = rsc_pkg::SEL_MANUAL;
        end else begin
          // with nothing valid the last choice is held
          if (best[2] && (cur_lost || outranks)) begin // R04 R14
            n.sel = best[1:0]; // R15
          end
          n.st = rsc_pkg::SEL_TRACK;
        end
      end
    endcase

    // write channel: address and data taken in either order
    if (axi_req.awvalid && q.rsp.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && q.rsp.wready) begin
      n.w_got = 1'b1;
      n.wdata = axi_req.wdata;
      n.wstrb = axi_req.wstrb;
    end
    if (q.rsp.bvalid && axi_req.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.rsp.bvalid) begin
      n.aw_got     = 1'b0;
      n.w_got      = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp  = mapped(widx) ? rsc_pkg::RESP_OKAY
                                  : rsc_pkg::RESP_SLVERR;
      if (q.wstrb[0]) begin
        if (widx == rsc_pkg::IDX_PRIO) begin
          n.prio = wm[7:0];
        end
        if (widx == rsc_pkg::IDX_MODE) begin
          n.mode = wm[7:0] & rsc_pkg::MODE_MASK;
        end
        if (widx == rsc_pkg::IDX_HOLD) begin
          n.hold = wm[7:0];
        end
        if (widx == rsc_pkg::IDX_CDIV) begin
          n.cdiv = wm[7:0] & rsc_pkg::CDIV_MASK;
        end
      end
      if (widx == rsc_pkg::IDX_LOOP) begin
        n.loop = merge(q.loop, q.wdata, q.wstrb) & rsc_pkg::LOOP_MASK;
      end
    end
    n.rsp.awready = !n.aw_got && !n.rsp.bvalid;
    n.rsp.wready  = !n.w_got && !n.rsp.bvalid;

    // read channel: one answer outstanding at most
    unique case (ridx)
      rsc_pkg::IDX_LOOP: rd = q.loop;
      rsc_pkg::IDX_PRIO: rd = {24'h0, q.prio};
      rsc_pkg::IDX_MODE: rd = {24'h0, q.mode};
      rsc_pkg::IDX_HOLD: rd = {24'h0, q.hold};
      rsc_pkg::IDX_CDIV: rd = {24'h0, q.cdiv};
      rsc_pkg::IDX_STAT: rd = {24'h0, q.los_s, 1'b0, is_auto, q.sel};
      default:           rd = 32'h0;
    endcase
    if (q.rsp.rvalid && axi_req.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && q.rsp.arready) begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rdata  = rd;
      n.rsp.rresp  = mapped(ridx) ? rsc_pkg::RESP_OKAY
                                  : rsc_pkg::RESP_SLVERR;
    end
    n.rsp.arready = !n.rsp.rvalid;

    // loop settings, registered so outputs come from flops
    n.cfg.phase_offset_code = q.loop[rsc_pkg::OFSEN_BIT]
        ? q.loop[rsc_pkg::OFS_LSB +: 5] : 5'h0; // R07
    n.cfg.phase_offset_tenths = 9'(n.cfg.phase_offset_code)
        * 9'(rsc_pkg::OFS_STEP_TENTHS); // R08
    n.cfg.synth_pump_current_code = q.loop[rsc_pkg::PUMP_LSB +: 5];
    n.cfg.pump_current_ua = 13'({1'b0, q.loop[rsc_pkg::PUMP_LSB +: 5]}
        + 6'h1) * 13'(rsc_pkg::PUMP_STEP_UA); // R09
    n.cfg.aux_osc_amplitude_code = q.loop[rsc_pkg::AMP_LSB +: 2];
    // amplitude does not depend on the output format
    n.cfg.aux_osc_amplitude_mv = amp_mv(q.loop[rsc_pkg::AMP_LSB +: 2]);
    n.cfg.output_format_sel = q.loop[rsc_pkg::FMT_BIT];
    n.cfg.activity_prescale_sel = q.mode[rsc_pkg::PRESCALE_BIT];
    n.cfg.activity_div_ratio = q.mode[rsc_pkg::PRESCALE_BIT]
        ? rsc_pkg::DIV_SLOW : rsc_pkg::DIV_FAST; // R06
    n.cfg.activity_counter_cfg = q.cdiv[1:0];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      q      <= '0;
      q.prio <= rsc_pkg::PRIO_RST;
      q.mode <= rsc_pkg::MODE_RST;
      q.hold <= rsc_pkg::HOLD_RST;
      q.cdiv <= rsc_pkg::CDIV_RST;
      q.loop <= rsc_pkg::LOOP_RST;
    end else begin
      q <= n;
    end
  end

  assign axi_rsp     = q.rsp;
  assign ref_sel     = q.sel;
  assign auto_active = q.mode[rsc_pkg::MODE_LSB];
  assign loop_cfg    = q.cfg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_track_quiet;
    q.st == rsc_pkg::SEL_TRACK && is_auto && !cur_lost && !revertive_switch_en_on;
  endsequence

  property p_manual_follows;
    q.st == rsc_pkg::SEL_MANUAL && !is_auto
      |=> ref_sel == $past(q.mode[1:0]);
  endproperty
  a_manual_follows: assert property (p_manual_follows) // R13
    else $error("manual selection not followed");

  property p_leave_auto;
    !is_auto |=> q.st == rsc_pkg::SEL_MANUAL;
  endproperty
  a_leave_auto: assert property (p_leave_auto) // R05
    else $error("automatic selector active in manual mode");

  property p_no_revert;
    s_track_quiet |=> $stable(ref_sel) && q.st == rsc_pkg::SEL_TRACK;
  endproperty
  a_no_revert: assert property (p_no_revert) // R03
    else $error("selection moved without revertive switching");

  property p_keep_higher;
    q.st == rsc_pkg::SEL_RESEL && is_auto && !cur_lost && !outranks
      |=> $stable(ref_sel);
  endproperty
  a_keep_higher: assert property (p_keep_higher) // R04
    else $error("switched to an input that does not outrank");

  property p_failover;
    q.st == rsc_pkg::SEL_RESEL && is_auto && cur_lost && best[2]
      |=> ref_sel == $past(best[1:0]) && !q.los_p[ref_sel];
  endproperty
  a_failover: assert property (p_failover) // R14
    else $error("failover did not pick the best valid input");

  property p_change_site;
    $changed(ref_sel) |-> $past(q.st) != rsc_pkg::SEL_TRACK;
  endproperty
  a_change_site: assert property (p_change_site) // R15
    else $error("selection changed outside a decision state");

  property p_offset_gate;
    !q.loop[rsc_pkg::OFSEN_BIT] |=> loop_cfg.phase_offset_code == 5'h0;
  endproperty
  a_offset_gate: assert property (p_offset_gate) // R07
    else $error("phase offset applied while disabled");

  property p_offset_scale;
    loop_cfg.phase_offset_tenths == 9'(loop_cfg.phase_offset_code) * 9'h9;
  endproperty
  a_offset_scale: assert property (p_offset_scale) // R08
    else $error("phase offset scale wrong");

  property p_pump;
    1'b1 |=> loop_cfg.pump_current_ua
      == 13'($past(q.loop[rsc_pkg::PUMP_LSB +: 5])) * 13'hc8 + 13'hc8;
  endproperty
  a_pump: assert property (p_pump) // R09
    else $error("pump current wrong");

  property p_prescale;
    q.mode[rsc_pkg::PRESCALE_BIT]
      |=> loop_cfg.activity_div_ratio == 3'h4;
  endproperty
  a_prescale: assert property (p_prescale) // R06
    else $error("monitor prescale not four");

endmodule

// [rsc_src_model.sv]
module rsc_src_model (
  input  wire logic       clk,
  input  wire logic [3:0] fail_cmd,
  output      logic [3:0] ref_los
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // source loss states
  // ----------------------------------------------------------------
  // loss flips 3 ns after each rising edge, between sampling edges, as a real
  // activity monitor would; the block must synchronise it
  initial ref_los = 4'h0;
  always @(posedge clk) ref_los <= #3 fail_cmd;
endmodule

// [rsc_ref_select_test.sv]
module rsc_ref_select_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clk;
  logic                   reset;
  logic [3:0]             fail_cmd;
  logic [3:0]             ref_los;
  rsc_pkg::rsc_axi_req_s  rq;
  rsc_pkg::rsc_axi_rsp_s  rs;
  logic [1:0]             ref_sel;
  logic                   auto_active;
  rsc_pkg::rsc_loop_cfg_s cfg;
  int                     fails;
  int                     compares;
  logic [31:0]            d;
  logic [1:0]             r;

  rsc_ref_select u_dut (
    .clk        (clk),
    .reset      (reset),
    .ref_los    (ref_los),
    .axi_req    (rq),
    .axi_rsp    (rs),
    .ref_sel    (ref_sel),
    .auto_active(auto_active),
    .loop_cfg   (cfg)
  );

  rsc_src_model u_src (
    .clk     (clk),
    .fail_cmd(fail_cmd),
    .ref_los (ref_los)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] resp);
    int n;
    n = 0;
    rq.awaddr  <= a;
    rq.wdata   <= v;
    rq.wstrb   <= 4'hf;
    rq.awvalid <= 1'b1;
    rq.wvalid  <= 1'b1;
    rq.bready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (rq.awvalid && rs.awready) rq.awvalid <= 1'b0;
      if (rq.wvalid && rs.wready) rq.wvalid <= 1'b0;
    end while (rs.bvalid !== 1'b1 && n < 50);
    // ready stays high between transfers, so no same-step drop and raise
    resp = rs.bresp;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] resp);
    int n;
    n = 0;
    rq.araddr  <= a;
    rq.arvalid <= 1'b1;
    rq.rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (rq.arvalid && rs.arready) rq.arvalid <= 1'b0;
    end while (rs.rvalid !== 1'b1 && n < 50);
    v = rs.rdata;
    resp = rs.rresp;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e);
  endtask

  task automatic wait_sel(input logic [1:0] e);
    int n;
    n = 0;
    while (ref_sel !== e && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(ref_sel, e);
  endtask

  task automatic set_fail(input logic [3:0] f);
    fail_cmd <= f;
    repeat (10) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdchk(8'h50, 32'he0);
    rdchk(8'h54, 32'h00);
    rdchk(8'h58, 32'h80);
    rdchk(8'h5c, 32'h80);
    rdchk(8'h4c, 32'h1800);
    chk(cfg.pump_current_ua, 32'd5000);
    chk(cfg.aux_osc_amplitude_mv, 32'd250);
    chk(cfg.activity_div_ratio, 32'd1);
    chk(ref_sel, 2'h0);
    rd(8'h80, d, r);
    chk(r, rsc_pkg::RESP_SLVERR);
    wr(8'h84, 32'h1, r);
    chk(r, rsc_pkg::RESP_SLVERR);
    $display("test reset done");
  endtask

  task automatic t_manual;
    wr(8'h54, 32'h01, r);
    wait_sel(2'h1);
    wr(8'h54, 32'h00, r);
    wait_sel(2'h0);
    // manual with holdover code and revertive set: field still rules
    wr(8'h54, 32'h19, r);
    wait_sel(2'h1);
    chk(auto_active, 1'b0);
    set_fail(4'h2);
    chk(ref_sel, 2'h1);
    set_fail(4'h0);
    $display("test manual done");
  endtask

  task automatic t_prio;
    wr(8'h54, 32'h03, r);
    wr(8'h50, 32'h00, r);
    wr(8'h54, 32'h04, r);
    wait_sel(2'h0);
    chk(auto_active, 1'b1);
    set_fail(4'h1);
    wait_sel(2'h1);
    set_fail(4'h3);
    wait_sel(2'h2);
    set_fail(4'h0);
    wr(8'h54, 32'h00, r);
    wr(8'h50, 32'h1b, r);
    wr(8'h54, 32'h0c, r);
    wait_sel(2'h3);
    set_fail(4'h8);
    wait_sel(2'h2);
    set_fail(4'h0);
    $display("test priority done");
  endtask

  task automatic t_revert;
    wr(8'h54, 32'h02, r);
    wr(8'h50, 32'he0, r);
    wr(8'h54, 32'h04, r);
    wait_sel(2'h0);
    set_fail(4'h1);
    wait_sel(2'h1);
    rdchk(8'h60, 32'h15);
    set_fail(4'h0);
    chk(ref_sel, 2'h1);
    wr(8'h54, 32'h01, r);
    wr(8'h54, 32'h14, r);
    wait_sel(2'h0);
    set_fail(4'h1);
    wait_sel(2'h1);
    // lower ranked input comes back: no switch
    set_fail(4'h5);
    set_fail(4'h1);
    chk(ref_sel, 2'h1);
    set_fail(4'h0);
    wait_sel(2'h0);
    $display("test revertive done");
  endtask

  task automatic t_loop;
    logic [9:0] mv [4];
    mv = '{10'd250, 10'd500, 10'd500, 10'd750};
    wr(8'h4c, 32'h0003_1f3f, r);
    chk(r, rsc_pkg::RESP_OKAY);
    @(posedge clk);
    chk(cfg.phase_offset_code, 32'd31);
    chk(cfg.phase_offset_tenths, 32'd279);
    chk(cfg.pump_current_ua, 32'd6400);
    chk(cfg.synth_pump_current_code, 32'd31);
    chk(cfg.aux_osc_amplitude_mv, 32'd750);
    wr(8'h4c, 32'h0000_0001, r);
    @(posedge clk);
    chk(cfg.phase_offset_code, 32'd0);
    chk(cfg.pump_current_ua, 32'd200);
    for (int i = 0; i < 8; i++) begin
      wr(8'h4c, (i << 16) | 32'h25, r);
      @(posedge clk);
      chk(cfg.aux_osc_amplitude_mv, mv[i%4]);
      chk(cfg.aux_osc_amplitude_code, 32'(i % 4));
      chk(cfg.output_format_sel, 32'(i / 4));
      chk(cfg.phase_offset_tenths, 32'd45);
    end
    wr(8'h54, 32'h20, r);
    @(posedge clk);
    chk(cfg.activity_div_ratio, 32'd4);
    chk(cfg.activity_prescale_sel, 1'b1);
    wr(8'h54, 32'hff, r);
    rdchk(8'h54, 32'h7f);
    wr(8'h5c, 32'hff, r);
    rdchk(8'h5c, 32'hcf);
    chk(cfg.activity_counter_cfg, 32'd3);
    wr(8'h54, 32'h00, r);
    @(posedge clk);
    chk(cfg.activity_div_ratio, 32'd1);
    $display("test loop settings done");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up;
  end

  initial begin
    fails = 0;
    compares = 0;
    rq = '0;
    fail_cmd = 4'h0;
    reset = 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset;
    t_manual;
    t_prio;
    t_revert;
    t_loop;
    wrap_up;
  end
endmodule
